// File: logic/dsd_decode.sv
// Data space decoder with I/O, static RAM and data EEPROM access.
`timescale 1ns/10ps
module dsd_decode
  import dsd_pkg::*;
#(
  parameter int EE_WRITE_CYCLES = DSD_EE_WRITE_CYC
)
(
  input  logic        clk_sys,
  input  logic        nrst,
  input  logic        npor,
  input  logic        req_valid,
  input  dsd_kind_t   req_kind,
  input  dsd_amode_t  req_amode,
  input  dsd_ptr_t    req_ptr,
  input  logic [15:0] req_addr,
  input  logic [5:0]  req_disp,
  input  logic [2:0]  req_bit,
  input  logic [7:0]  req_wdata,
  input  logic [7:0]  flag_set,
  input  logic        sleep_pdown,
  input  logic        pc_load,
  input  logic        pc_advance,
  input  logic [13:0] pc_target,
  output logic        req_ready,
  output logic        rsp_valid,
  output logic [7:0]  rsp_rdata,
  output logic        rsp_skip,
  output logic        rsp_ignored,
  output logic        ee_write_busy,
  output logic        osc_run,
  output logic [13:0] program_counter
);

  localparam logic [DSD_EE_CNT_W-1:0] EE_LOAD =
    DSD_EE_CNT_W'(EE_WRITE_CYCLES - 1);

  logic [7:0]  rf     [DSD_REG_COUNT];
  logic [7:0]  io_mem [DSD_IO_COUNT];
  logic [7:0]  sram   [DSD_SRAM_BYTES];
  logic [7:0]  ee_mem [DSD_EE_BYTES];

  dsd_phase_t  phase;
  dsd_phase_t  next_phase;
  logic [2:0]  hold_cnt;
  logic [2:0]  next_hold_cnt;
  logic        next_req_ready;
  logic        next_rsp_valid;
  logic [7:0]  next_rsp_rdata;
  logic        next_rsp_skip;
  logic        next_rsp_ignored;
  logic [10:0] pend_addr;
  logic [10:0] next_pend_addr;
  logic        pend_write;
  logic        next_pend_write;
  logic [7:0]  pend_wd;
  logic [7:0]  next_pend_wd;
  logic [9:0]  ee_addr;
  logic [9:0]  next_ee_addr;
  logic [7:0]  ee_data;
  logic [7:0]  next_ee_data;
  logic [2:0]  arm_cnt;
  logic [2:0]  next_arm_cnt;
  logic [7:0]  flags;
  logic [7:0]  next_flags;
  logic        sleep_wr;
  logic        next_sleep_wr;
  logic        next_osc_run;
  logic [13:0] next_pc;

  logic [DSD_EE_CNT_W-1:0] ee_cnt;
  logic [DSD_EE_CNT_W-1:0] next_ee_cnt;
  logic [9:0]  ee_waddr;
  logic [9:0]  next_ee_waddr;
  logic [7:0]  ee_wdata;
  logic [7:0]  next_ee_wdata;
  logic        next_ee_busy;
  logic        ee_mem_we;

  logic        accept;
  logic        arm_active;
  logic [15:0] ptr_val;
  logic [15:0] eff;
  logic [15:0] acc_addr;
  logic [15:0] io_off;
  logic [5:0]  io_a;
  dsd_region_t acc_region;
  logic        range_ok;
  logic        mapped;
  logic [7:0]  mask;
  logic [7:0]  acc_rd;
  logic [7:0]  acc_wd;
  logic        acc_write;
  logic        io_wr;
  logic        io_mem_we;
  logic        ptr_upd;
  logic [15:0] new_ptr;
  logic [4:0]  plo;
  logic [31:0] rf_we;
  logic [7:0]  rf_wd [DSD_REG_COUNT];
  logic        ee_start;
  logic        ee_rd_go;
  logic        arm_set;
  logic [7:0]  flag_clr;

  assign arm_active = arm_cnt != 3'h0;

  function automatic logic [4:0] ptr_index(input dsd_ptr_t p);
    unique case (p)
      DSD_P_X: return DSD_PTR_X;
      DSD_P_Y: return DSD_PTR_Y;
      DSD_P_Z: return DSD_PTR_Z;
      default: return DSD_PTR_Z;
    endcase
  endfunction

  // Pointer pairs sit on even indices, so the high byte is index | 1.
  function automatic logic [15:0] ptr_read(input dsd_ptr_t p);
    logic [4:0] lo;
    lo = ptr_index(p);
    return {rf[lo | 5'h01], rf[lo]};
  endfunction

  // Reserved control bits and unused address bits read as zero.
  function automatic logic [7:0] io_read(input logic [5:0] a);
    if (a == DSD_IO_FLAGS)
      return flags;
    else if (a == DSD_IO_EE_CTRL)
      return {5'h00, arm_active, ee_write_busy, 1'b0};
    else if (a == DSD_IO_EE_DATA)
      return ee_data;
    else if (a == DSD_IO_EE_ALO)
      return ee_addr[7:0];
    else if (a == DSD_IO_EE_AHI)
      return {6'h00, ee_addr[9:8]};
    else
      return io_mem[a];
  endfunction

  always_comb
  begin
    accept = req_valid && req_ready;
    ptr_val = ptr_read(req_ptr);
    unique case (req_amode)
      DSD_AM_DIRECT: eff = req_addr;
      DSD_AM_DISP: eff = ptr_val + {10'h000, req_disp};
      DSD_AM_PREDEC: eff = ptr_val - 16'h0001;
      DSD_AM_IND: eff = ptr_val;
      DSD_AM_POSTINC: eff = ptr_val;
      default: eff = ptr_val;
    endcase
    acc_addr = eff;
    range_ok = 1'b1;
    unique case (req_kind)
      DSD_DATA_LOAD_INSTR, DSD_DATA_STORE_INSTR:
        acc_addr = eff;
      DSD_IO_IN_INSTR, DSD_IO_OUT_INSTR:
      begin
        acc_addr = DSD_IO_BASE + {10'h000, req_addr[5:0]};
        range_ok = req_addr[15:6] == 10'h000;
      end
      DSD_IO_BIT_SET_INSTR, DSD_IO_BIT_CLEAR_INSTR,
      DSD_SKIP_IF_IO_BIT_SET_INSTR, DSD_SKIP_IF_IO_BIT_CLR_INSTR:
      begin
        acc_addr = DSD_IO_BASE + {11'h000, req_addr[4:0]};
        range_ok = req_addr[15:5] == 11'h000;
      end
    endcase
    acc_region = dsd_region(acc_addr);
    mapped = range_ok && (acc_region != DSD_RG_NONE);
    io_off = acc_addr - DSD_IO_BASE;
    io_a = io_off[5:0];
    mask = 8'h01 << req_bit;
    unique case (acc_region)
      DSD_RG_REG: acc_rd = rf[acc_addr[4:0]];
      DSD_RG_IO: acc_rd = io_read(io_a);
      DSD_RG_SRAM: acc_rd = 8'h00;
      DSD_RG_NONE: acc_rd = 8'h00;
    endcase
    // Set flags read back as one and are written back as one.
    unique case (req_kind)
      DSD_IO_BIT_SET_INSTR: acc_wd = acc_rd | mask;
      DSD_IO_BIT_CLEAR_INSTR: acc_wd = acc_rd & ~mask;
      DSD_DATA_STORE_INSTR, DSD_IO_OUT_INSTR: acc_wd = req_wdata;
      default: acc_wd = 8'h00;
    endcase
    acc_write = accept && mapped &&
      (req_kind == DSD_DATA_STORE_INSTR ||
       req_kind == DSD_IO_OUT_INSTR ||
       req_kind == DSD_IO_BIT_SET_INSTR ||
       req_kind == DSD_IO_BIT_CLEAR_INSTR);
    io_wr = acc_write && (acc_region == DSD_RG_IO);
    io_mem_we = io_wr && (io_a < DSD_IO_FLAGS || io_a > DSD_IO_EE_AHI);
    ptr_upd = accept &&
      (req_kind == DSD_DATA_LOAD_INSTR ||
       req_kind == DSD_DATA_STORE_INSTR) &&
      (req_amode == DSD_AM_PREDEC || req_amode == DSD_AM_POSTINC);
    new_ptr = (req_amode == DSD_AM_PREDEC) ? eff : ptr_val + 16'h0001;
    plo = ptr_index(req_ptr);
    rf_we = 32'h0000_0000;
    for (int i = 0; i < DSD_REG_COUNT; i++)
    begin
      rf_wd[i] = 8'h00;
    end
    if (acc_write && acc_region == DSD_RG_REG)
    begin
      rf_we[acc_addr[4:0]] = 1'b1;
      rf_wd[acc_addr[4:0]] = acc_wd;
    end
    // The pointer update wins if a store targets its own pointer.
    if (ptr_upd)
    begin
      rf_we[plo] = 1'b1;
      rf_wd[plo] = new_ptr[7:0];
      rf_we[plo | 5'h01] = 1'b1;
      rf_wd[plo | 5'h01] = new_ptr[15:8];
    end
  end

  always_comb
  begin
    next_phase = phase;
    next_hold_cnt = hold_cnt;
    next_req_ready = req_ready;
    next_rsp_valid = 1'b0;
    next_rsp_rdata = rsp_rdata;
    next_rsp_skip = 1'b0;
    next_rsp_ignored = 1'b0;
    next_pend_addr = pend_addr;
    next_pend_write = pend_write;
    next_pend_wd = pend_wd;
    next_ee_addr = ee_addr;
    next_ee_data = ee_data;
    next_arm_cnt = arm_active ? arm_cnt - 3'h1 : 3'h0;
    flag_clr = 8'h00;
    ee_start = 1'b0;
    ee_rd_go = 1'b0;
    arm_set = 1'b0;
    // Writes to the address are dropped while a write is running.
    if (io_wr && io_a == DSD_IO_EE_ALO && !ee_write_busy)
      next_ee_addr[7:0] = acc_wd;
    if (io_wr && io_a == DSD_IO_EE_AHI && !ee_write_busy)
      next_ee_addr[9:8] = acc_wd[1:0];
    if (io_wr && io_a == DSD_IO_EE_DATA)
      next_ee_data = acc_wd;
    if (io_wr && io_a == DSD_IO_FLAGS)
      flag_clr = acc_wd;
    if (io_wr && io_a == DSD_IO_EE_CTRL)
    begin
      arm_set = acc_wd[DSD_CTRL_ARM];
      ee_start = acc_wd[DSD_CTRL_WR] && arm_active &&
        !ee_write_busy;
      ee_rd_go = acc_wd[DSD_CTRL_RD] && !ee_write_busy;
    end
    if (arm_set)
      next_arm_cnt = DSD_ARM_WINDOW;
    if (ee_rd_go)
      next_ee_data = ee_mem[ee_addr];
    unique case (phase)
      DSD_PH_IDLE:
      begin
        next_req_ready = 1'b1;
        if (accept && mapped && acc_region == DSD_RG_SRAM)
        begin
          next_req_ready = 1'b0;
          next_phase = DSD_PH_SRAM;
          next_pend_addr = io_off[10:0] - 11'h040;
          next_pend_write = acc_write;
          next_pend_wd = acc_wd;
        end
        else if (accept)
        begin
          next_req_ready = 1'b0;
          next_rsp_valid = 1'b1;
          next_rsp_rdata = acc_rd;
          next_rsp_ignored = !mapped;
          next_rsp_skip = mapped && (
            (req_kind == DSD_SKIP_IF_IO_BIT_SET_INSTR &&
             (acc_rd & mask) != 8'h00) ||
            (req_kind == DSD_SKIP_IF_IO_BIT_CLR_INSTR &&
             (acc_rd & mask) == 8'h00));
          if (ee_rd_go)
          begin
            next_phase = DSD_PH_HOLD;
            next_hold_cnt = DSD_EE_RD_STALL;
          end
          else if (ee_start)
          begin
            next_phase = DSD_PH_HOLD;
            next_hold_cnt = DSD_EE_WR_STALL;
          end
        end
      end
      DSD_PH_SRAM:
      begin
        next_phase = DSD_PH_IDLE;
        next_rsp_valid = 1'b1;
        next_rsp_rdata = pend_write ? 8'h00 : sram[pend_addr];
      end
      DSD_PH_HOLD:
      begin
        if (hold_cnt == 3'h0)
        begin
          next_phase = DSD_PH_IDLE;
          next_req_ready = 1'b1;
        end
        else
          next_hold_cnt = hold_cnt - 3'h1;
      end
      default:
        next_phase = DSD_PH_IDLE;
    endcase
    // A flag raised in the cycle it is cleared stays set.
    next_flags = (flags & ~flag_clr) | flag_set;
    next_sleep_wr = sleep_pdown && (sleep_wr || ee_write_busy);
    next_osc_run = !sleep_pdown || ee_write_busy || sleep_wr;
    if (pc_load)
      next_pc = pc_target;
    else if (pc_advance)
      next_pc = program_counter + 14'h0001;
    else
      next_pc = program_counter;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      phase <= DSD_PH_IDLE;
      hold_cnt <= 3'h0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
      rsp_skip <= 1'b0;
      rsp_ignored <= 1'b0;
      pend_addr <= 11'h000;
      pend_write <= 1'b0;
      pend_wd <= 8'h00;
      ee_addr <= 10'h000;
      ee_data <= 8'h00;
      arm_cnt <= 3'h0;
      flags <= 8'h00;
      sleep_wr <= 1'b0;
      osc_run <= 1'b1;
      program_counter <= 14'h0000;
    end
    else
    begin
      phase <= next_phase;
      hold_cnt <= next_hold_cnt;
      req_ready <= next_req_ready;
      rsp_valid <= next_rsp_valid;
      rsp_rdata <= next_rsp_rdata;
      rsp_skip <= next_rsp_skip;
      rsp_ignored <= next_rsp_ignored;
      pend_addr <= next_pend_addr;
      pend_write <= next_pend_write;
      pend_wd <= next_pend_wd;
      ee_addr <= next_ee_addr;
      ee_data <= next_ee_data;
      arm_cnt <= next_arm_cnt;
      flags <= next_flags;
      sleep_wr <= next_sleep_wr;
      osc_run <= next_osc_run;
      program_counter <= next_pc;
    end
  end

  // The write engine sees only the power-on reset, so a system reset
  // in mid-write lets the byte finish.
  always_comb
  begin
    next_ee_busy = ee_write_busy;
    next_ee_cnt = ee_cnt;
    next_ee_waddr = ee_waddr;
    next_ee_wdata = ee_wdata;
    ee_mem_we = 1'b0;
    if (ee_write_busy)
    begin
      if (ee_cnt == '0)
      begin
        next_ee_busy = 1'b0;
        ee_mem_we = 1'b1;
      end
      else
        next_ee_cnt = ee_cnt - 1'b1;
    end
    else if (ee_start)
    begin
      next_ee_busy = 1'b1;
      next_ee_cnt = EE_LOAD;
      next_ee_waddr = ee_addr;
      next_ee_wdata = ee_data;
    end
  end

  always_ff @(posedge clk_sys or negedge npor)
  begin
    if (!npor)
    begin
      ee_write_busy <= 1'b0;
      ee_cnt <= '0;
      ee_waddr <= 10'h000;
      ee_wdata <= 8'h00;
    end
    else
    begin
      ee_write_busy <= next_ee_busy;
      ee_cnt <= next_ee_cnt;
      ee_waddr <= next_ee_waddr;
      ee_wdata <= next_ee_wdata;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < DSD_REG_COUNT; i++)
    begin
      if (rf_we[i])
        rf[i] <= rf_wd[i];
    end
    if (io_mem_we)
      io_mem[io_a] <= acc_wd;
    if (phase == DSD_PH_SRAM && pend_write)
      sram[pend_addr] <= pend_wd;
    if (ee_mem_we)
      ee_mem[ee_waddr] <= ee_wdata;
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_sram_two;
    accept && mapped && acc_region == DSD_RG_SRAM
      |=> !rsp_valid ##1 rsp_valid ##1 req_ready;
  endproperty
  a_sram_two: assert property (p_sram_two)
    else $error("static RAM access not two cycles");

  property p_fast;
    accept && acc_region != DSD_RG_SRAM && !ee_rd_go && !ee_start
      |=> rsp_valid && !req_ready ##1 req_ready;
  endproperty
  a_fast: assert property (p_fast)
    else $error("register or I/O access not one cycle");

  property p_rd_stall;
    accept && ee_rd_go |=> !req_ready [*5] ##1 req_ready;
  endproperty
  a_rd_stall: assert property (p_rd_stall)
    else $error("EEPROM read stall not four cycles");

  property p_wr_stall;
    accept && ee_start |=> !req_ready [*3] ##1 req_ready;
  endproperty
  a_wr_stall: assert property (p_wr_stall)
    else $error("EEPROM write stall not two cycles");

  // A re-arm inside the window legally stretches it, so any arming in
  // the last four cycles may keep the window open.
  property p_arm;
    arm_set |=> arm_active [*4] ##1 (!arm_active || $past(arm_set) ||
      $past(arm_set, 2) || $past(arm_set, 3) || $past(arm_set, 4));
  endproperty
  a_arm: assert property (p_arm)
    else $error("arm window not four cycles");

  property p_start;
    ee_start |-> arm_active ##1 ee_write_busy;
  endproperty
  a_start: assert property (p_start)
    else $error("write started without arming");

  property p_done;
    @(posedge clk_sys) disable iff (!npor)
      ee_write_busy && ee_cnt == '0 |=> !ee_write_busy;
  endproperty
  a_done: assert property (p_done)
    else $error("write strobe not cleared at end");

  property p_keep;
    @(posedge clk_sys) disable iff (!npor)
      !nrst && ee_write_busy && ee_cnt != '0 |=> ee_write_busy;
  endproperty
  a_keep: assert property (p_keep)
    else $error("reset aborted EEPROM write");

  property p_bit_range;
    accept && req_kind == DSD_IO_BIT_SET_INSTR && !range_ok
      |=> rsp_ignored && !rsp_skip;
  endproperty
  a_bit_range: assert property (p_bit_range)
    else $error("bit instruction acted above 1F");

  property p_w1c;
    1'b1 |=> (flags & $past(flag_clr) & ~$past(flag_set)) == 8'h00
      && (flags & $past(flag_set)) == $past(flag_set);
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write-one-to-clear flag wrong");

  property p_postinc;
    ptr_upd && req_amode == DSD_AM_POSTINC
      |=> ptr_read($past(req_ptr)) == $past(ptr_val) + 16'h0001;
  endproperty
  a_postinc: assert property (p_postinc)
    else $error("pointer not incremented");

  property p_pc;
    pc_advance && !pc_load
      |=> program_counter == $past(program_counter) + 14'h0001;
  endproperty
  a_pc: assert property (p_pc)
    else $error("program counter did not advance");

  property p_sleep;
    sleep_pdown && ee_write_busy |=> osc_run;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("oscillator stopped during write");

endmodule

// File: logic/dsd_pkg.sv
// Constants, types and region decode shared by the data space decoder.
// Contract
// - First 96 addresses are registers and I/O, next 2048 static RAM.
// - 32 working registers and 64 I/O registers, all reachable.
// - Registers 26 to 31 form the X, Y and Z pointers.
// - Direct addressing reaches the whole data space.
// - Displacement mode adds up to 63 to the Y or Z pointer.
// - Pre-decrement and post-increment update the pointer used.
// - A static RAM access takes two clock cycles.
// - Bit instructions work on I/O 00 to 1F only.
// - I/O instructions use 00 to 3F; data space adds 20.
// - Some flags clear when a one is written to them.
// - Bit set or clear writes back the whole register.
// - The program counter is 14 bits wide.
// - 1024 bytes of byte-wide EEPROM, registers in I/O space.
// - An EEPROM read stalls the CPU four cycles.
// - An EEPROM write stalls the CPU two cycles.
// - The write is self-timed with a ready indication.
// - A write starts only after the arming sequence.
// - A write survives power-down, which keeps the oscillator on.
// - System reset (nrst) does not abort a write in progress.
// - EEPROM bytes are addressed linearly 0 to 1023.
// - Strobe within four cycles of arming starts; arm clears after four.
// - Hardware clears the write strobe when the write ends.
package dsd_pkg;
  localparam logic [15:0] DSD_IO_BASE = 16'h0020;
  localparam logic [15:0] DSD_SRAM_BASE = 16'h0060;
  localparam logic [15:0] DSD_DATA_END = 16'h0860;
  localparam int DSD_REG_COUNT = 32;
  localparam int DSD_IO_COUNT = 64;
  localparam int DSD_SRAM_BYTES = 2048;
  localparam int DSD_EE_BYTES = 1024;
  localparam int DSD_PC_W = 14;
  localparam logic [4:0] DSD_PTR_X = 5'h1A;
  localparam logic [4:0] DSD_PTR_Y = 5'h1C;
  localparam logic [4:0] DSD_PTR_Z = 5'h1E;
  localparam logic [5:0] DSD_IO_FLAGS = 6'h1B;
  localparam logic [5:0] DSD_IO_EE_CTRL = 6'h1C;
  localparam logic [5:0] DSD_IO_EE_DATA = 6'h1D;
  localparam logic [5:0] DSD_IO_EE_ALO = 6'h1E;
  localparam logic [5:0] DSD_IO_EE_AHI = 6'h1F;
  localparam int DSD_CTRL_RD = 0;
  localparam int DSD_CTRL_WR = 1;
  localparam int DSD_CTRL_ARM = 2;
  localparam logic [2:0] DSD_ARM_WINDOW = 3'h4;
  localparam logic [2:0] DSD_EE_RD_STALL = 3'h4;
  localparam logic [2:0] DSD_EE_WR_STALL = 3'h2;
  localparam int DSD_CLK_NS = 25;
  localparam int DSD_EE_WRITE_NS = 8500000;
  localparam int DSD_EE_WRITE_CYC = DSD_EE_WRITE_NS / DSD_CLK_NS;
  localparam int DSD_EE_CNT_W = 20;

  typedef enum logic [2:0] {
    DSD_DATA_LOAD_INSTR = 3'h0,
    DSD_DATA_STORE_INSTR = 3'h1,
    DSD_IO_IN_INSTR = 3'h2,
    DSD_IO_OUT_INSTR = 3'h3,
    DSD_IO_BIT_SET_INSTR = 3'h4,
    DSD_IO_BIT_CLEAR_INSTR = 3'h5,
    DSD_SKIP_IF_IO_BIT_SET_INSTR = 3'h6,
    DSD_SKIP_IF_IO_BIT_CLR_INSTR = 3'h7
  } dsd_kind_t;

  typedef enum logic [2:0] {
    DSD_AM_DIRECT = 3'h0,
    DSD_AM_IND = 3'h1,
    DSD_AM_DISP = 3'h2,
    DSD_AM_PREDEC = 3'h3,
    DSD_AM_POSTINC = 3'h4
  } dsd_amode_t;

  typedef enum logic [1:0] {
    DSD_P_X = 2'h0,
    DSD_P_Y = 2'h1,
    DSD_P_Z = 2'h2
  } dsd_ptr_t;

  typedef enum logic [1:0] {
    DSD_RG_REG = 2'h0,
    DSD_RG_IO = 2'h1,
    DSD_RG_SRAM = 2'h2,
    DSD_RG_NONE = 2'h3
  } dsd_region_t;

  typedef enum logic [1:0] {
    DSD_PH_IDLE = 2'h0,
    DSD_PH_SRAM = 2'h1,
    DSD_PH_HOLD = 2'h2
  } dsd_phase_t;

  function automatic dsd_region_t dsd_region(input logic [15:0] a);
    if (a < DSD_IO_BASE)
      return DSD_RG_REG;
    else if (a < DSD_SRAM_BASE)
      return DSD_RG_IO;
    else if (a < DSD_DATA_END)
      return DSD_RG_SRAM;
    else
      return DSD_RG_NONE;
  endfunction
endpackage

// File: verif/dsd_cpu_model.sv
// CPU pipeline model that issues one data request and collects its answer.
`timescale 1ns/10ps
module dsd_cpu_model
  import dsd_pkg::*;
(
  input  logic        clk_sys,
  input  logic        req_ready,
  input  logic        rsp_valid,
  input  logic [7:0]  rsp_rdata,
  input  logic        rsp_skip,
  input  logic        rsp_ignored,
  output logic        req_valid,
  output dsd_kind_t   req_kind,
  output dsd_amode_t  req_amode,
  output dsd_ptr_t    req_ptr,
  output logic [15:0] req_addr,
  output logic [5:0]  req_disp,
  output logic [2:0]  req_bit,
  output logic [7:0]  req_wdata
);
  logic [7:0] rdata;
  logic       skip;
  logic       ign;
  logic [7:0] lat;
  logic [7:0] gap;
  logic       hung;

  initial
  begin
    req_valid = 1'b0;
    req_kind  = DSD_DATA_LOAD_INSTR;
    req_amode = DSD_AM_DIRECT;
    req_ptr   = DSD_P_X;
    req_addr  = 16'h0000;
    req_disp  = 6'h00;
    req_bit   = 3'h0;
    req_wdata = 8'h00;
  end

  // Called at a falling edge; the request is held until a taking edge.
  task automatic issue(input dsd_kind_t k, input dsd_amode_t m,
                       input dsd_ptr_t p, input logic [15:0] a,
                       input logic [5:0] d, input logic [2:0] b,
                       input logic [7:0] w);
    bit took;
    int i;
    took = 0;
    lat = 8'h00;
    gap = 8'h00;
    req_kind = k;
    req_amode = m;
    req_ptr = p;
    req_addr = a;
    req_disp = d;
    req_bit = b;
    req_wdata = w;
    req_valid = 1'b1;
    for (i = 0; i < 30 && !took; i++)
    begin
      @(posedge clk_sys);
      took = (req_ready === 1'b1);
    end
    hung = !took;
    for (i = 1; i < 30; i++)
    begin
      @(negedge clk_sys);
      if (i == 1)
      begin
        // Released address, data and displacement lines show inverted values so stale data never matches.
        req_valid = 1'b0;
        req_addr = ~req_addr;
        req_wdata = ~req_wdata;
        req_disp = ~req_disp;
      end
      if (rsp_valid === 1'b1)
      begin
        lat = 8'(i);
        rdata = rsp_rdata;
        skip = rsp_skip;
        ign = rsp_ignored;
      end
      if (req_ready === 1'b1)
        break;
      gap++;
    end
    hung = hung | (i == 30);
  endtask
endmodule

// File: verif/tb_data_space_io_decode.sv
// Self-checking bench for the data space decoder.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module tb_data_space_io_decode
  import dsd_pkg::*;
;
  logic        clk_sys, nrst, npor, sleep_pdown, pc_load, pc_advance;
  logic        req_valid, req_ready, rsp_valid, rsp_skip, rsp_ignored;
  logic        ee_write_busy, osc_run;
  dsd_kind_t   req_kind;
  dsd_amode_t  req_amode;
  dsd_ptr_t    req_ptr;
  logic [15:0] req_addr;
  logic [5:0]  req_disp;
  logic [2:0]  req_bit;
  logic [7:0]  req_wdata, flag_set, rsp_rdata;
  logic [13:0] pc_target, program_counter;
  int          n_mismatch, compares, i;
  wire  [7:0]  rd = dsd_cpu_model_i.rdata;
  wire  [7:0]  lat = dsd_cpu_model_i.lat;
  wire  [7:0]  gap = dsd_cpu_model_i.gap;

  dsd_decode #(.EE_WRITE_CYCLES(12)) dsd_decode_i (.clk_sys, .nrst, .npor,
    .req_valid, .req_kind, .req_amode, .req_ptr, .req_addr, .req_disp,
    .req_bit, .req_wdata, .flag_set, .sleep_pdown, .pc_load, .pc_advance,
    .pc_target, .req_ready, .rsp_valid, .rsp_rdata, .rsp_skip,
    .rsp_ignored, .ee_write_busy, .osc_run, .program_counter);
  dsd_cpu_model dsd_cpu_model_i (.clk_sys, .req_ready, .rsp_valid,
    .rsp_rdata, .rsp_skip, .rsp_ignored, .req_valid, .req_kind, .req_amode,
    .req_ptr, .req_addr, .req_disp, .req_bit, .req_wdata);

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic op(dsd_kind_t k, dsd_amode_t m, dsd_ptr_t p,
                    logic [15:0] a, logic [5:0] d, logic [2:0] b,
                    logic [7:0] w);
    dsd_cpu_model_i.issue(k, m, p, a, d, b, w);
    if (dsd_cpu_model_i.hung)
    begin
      n_mismatch++;
      give_verdict();
    end
  endtask

  task automatic st(logic [15:0] a, logic [7:0] w);
    op(DSD_DATA_STORE_INSTR, DSD_AM_DIRECT, DSD_P_X, a, 6'h00, 3'h0, w);
  endtask

  task automatic ld(logic [15:0] a);
    op(DSD_DATA_LOAD_INSTR, DSD_AM_DIRECT, DSD_P_X, a, 6'h00, 3'h0, 8'h00);
  endtask

  task automatic iw(logic [15:0] a, logic [7:0] w);
    op(DSD_IO_OUT_INSTR, DSD_AM_DIRECT, DSD_P_X, a, 6'h00, 3'h0, w);
  endtask

  task automatic ir(logic [15:0] a);
    op(DSD_IO_IN_INSTR, DSD_AM_DIRECT, DSD_P_X, a, 6'h00, 3'h0, 8'h00);
  endtask

  task automatic bit_op(dsd_kind_t k, logic [15:0] a, logic [2:0] b);
    op(k, DSD_AM_DIRECT, DSD_P_X, a, 6'h00, b, 8'h00);
  endtask

  task automatic t_map;
    st(16'h0005, 8'h5A);
    ld(16'h0005);
    `CHK("reg", 8'h5A, rd);
    `CHK("reg_lat", 8'h01, lat);
    iw(16'h0010, 8'h3C);
    ld(16'h0030);
    `CHK("io_alias", 8'h3C, rd);
    st(16'h0060, 8'h11);
    `CHK("sram_gap", 8'h02, gap);
    st(16'h085F, 8'h22);
    ld(16'h0060);
    `CHK("sram_lo", 8'h11, rd);
    `CHK("sram_lat", 8'h02, lat);
    ld(16'h085F);
    `CHK("sram_hi", 8'h22, rd);
    ld(16'h0860);
    `CHK("unmapped", 1'b1, dsd_cpu_model_i.ign);
    ir(16'h0040);
    `CHK("io_range", 1'b1, dsd_cpu_model_i.ign);
  endtask

  task automatic t_ptr;
    st(16'h001A, 8'h00);
    st(16'h001B, 8'h01);
    op(DSD_DATA_STORE_INSTR, DSD_AM_POSTINC, DSD_P_X, 0, 0, 0, 8'h77);
    ld(16'h001A);
    `CHK("x_inc", 8'h01, rd);
    ld(16'h0100);
    `CHK("x_data", 8'h77, rd);
    op(DSD_DATA_LOAD_INSTR, DSD_AM_PREDEC, DSD_P_X, 0, 0, 0, 8'h00);
    `CHK("x_dec_rd", 8'h77, rd);
    ld(16'h001A);
    `CHK("x_dec", 8'h00, rd);
    st(16'h001C, 8'h00);
    st(16'h001D, 8'h01);
    st(16'h013F, 8'h99);
    op(DSD_DATA_LOAD_INSTR, DSD_AM_DISP, DSD_P_Y, 0, 6'h3F, 0, 8'h00);
    `CHK("y_disp", 8'h99, rd);
    st(16'h001E, 8'h3F);
    st(16'h001F, 8'h01);
    op(DSD_DATA_LOAD_INSTR, DSD_AM_IND, DSD_P_Z, 0, 0, 0, 8'h00);
    `CHK("z_ind", 8'h99, rd);
  endtask

  task automatic t_bits;
    iw(16'h0010, 8'h00);
    bit_op(DSD_IO_BIT_SET_INSTR, 16'h0010, 3'h3);
    ir(16'h0010);
    `CHK("bit_set", 8'h08, rd);
    bit_op(DSD_SKIP_IF_IO_BIT_SET_INSTR, 16'h0010, 3'h3);
    `CHK("skip_set", 1'b1, dsd_cpu_model_i.skip);
    bit_op(DSD_SKIP_IF_IO_BIT_CLR_INSTR, 16'h0010, 3'h3);
    `CHK("skip_clr", 1'b0, dsd_cpu_model_i.skip);
    bit_op(DSD_IO_BIT_CLEAR_INSTR, 16'h0010, 3'h3);
    ir(16'h0010);
    `CHK("bit_clr", 8'h00, rd);
    bit_op(DSD_SKIP_IF_IO_BIT_CLR_INSTR, 16'h0010, 3'h3);
    `CHK("skip_clr_hit", 1'b1, dsd_cpu_model_i.skip);
    bit_op(DSD_IO_BIT_SET_INSTR, 16'h0020, 3'h0);
    `CHK("bit_range", 1'b1, dsd_cpu_model_i.ign);
    flag_set = 8'h81;
    @(negedge clk_sys);
    flag_set = 8'h00;
    ir(16'h001B);
    `CHK("flags", 8'h81, rd);
    iw(16'h001B, 8'h01);
    ir(16'h001B);
    `CHK("w1c", 8'h80, rd);
    bit_op(DSD_IO_BIT_CLEAR_INSTR, 16'h001B, 3'h0);
    ir(16'h001B);
    `CHK("rmw_clr", 8'h00, rd);
  endtask

  task automatic t_ee;
    iw(16'h001E, 8'hFF);
    iw(16'h001F, 8'h03);
    iw(16'h001D, 8'h5C);
    iw(16'h001C, 8'h04);
    iw(16'h001C, 8'h02);
    `CHK("wr_stall", 8'h03, gap);
    `CHK("busy", 1'b1, ee_write_busy);
    sleep_pdown = 1'b1;
    nrst = 1'b0;
    @(negedge clk_sys);
    nrst = 1'b1;
    `CHK("busy_rst", 1'b1, ee_write_busy);
    for (i = 0; i < 40 && ee_write_busy !== 1'b0; i++)
      @(negedge clk_sys);
    `CHK("wr_done", 1'b0, ee_write_busy);
    `CHK("osc_keep", 1'b1, osc_run);
    sleep_pdown = 1'b0;
    @(negedge clk_sys);
    sleep_pdown = 1'b1;
    repeat (2) @(negedge clk_sys);
    `CHK("osc_off", 1'b0, osc_run);
    sleep_pdown = 1'b0;
    iw(16'h001E, 8'hFF);
    iw(16'h001F, 8'h03);
    iw(16'h001D, 8'h00);
    iw(16'h001C, 8'h01);
    `CHK("rd_stall", 8'h05, gap);
    ir(16'h001D);
    `CHK("ee_data", 8'h5C, rd);
    iw(16'h001C, 8'h02);
    `CHK("no_arm", 1'b0, ee_write_busy);
    iw(16'h001C, 8'h04);
    ir(16'h001C);
    `CHK("arm_rd", 8'h04, rd);
    repeat (3) @(negedge clk_sys);
    ir(16'h001C);
    `CHK("arm_clr", 8'h00, rd);
    iw(16'h001C, 8'h02);
    `CHK("late_wr", 1'b0, ee_write_busy);
  endtask

  task automatic t_pc;
    pc_target = 14'h3FFF;
    pc_load = 1'b1;
    @(negedge clk_sys);
    pc_load = 1'b0;
    pc_advance = 1'b1;
    `CHK("pc_load", 14'h3FFF, program_counter);
    @(negedge clk_sys);
    pc_advance = 1'b0;
    `CHK("pc_wrap", 14'h0000, program_counter);
  endtask

  initial
  begin
    {nrst, npor, sleep_pdown, pc_load, pc_advance} = 5'h00;
    flag_set = 8'h00;
    pc_target = 14'h0000;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    {nrst, npor} = 2'h3;
    `CHK("pc_rst", 14'h0000, program_counter);
    `CHK("osc_rst", 1'b1, osc_run);
    t_map();
    t_ptr();
    t_bits();
    t_ee();
    t_pc();
    give_verdict();
  end
endmodule
